// file: eea_regs.svh
`ifndef EEA_REGS_SVH
`define EEA_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EEA_OFS_PW_ZERO 8'h21
`define EEA_OFS_PW_ONE 8'h22
`define EEA_OFS_PW_TWO 8'h23
`define EEA_OFS_PW_THREE 8'h24
`define EEA_OFS_NVM_ADDR 8'h25
`define EEA_OFS_NVM_DATA 8'h26
`define EEA_OFS_NVM_CMD 8'h27

// ****************************************************************
// nonvolatile map and mirror layout
// ****************************************************************
`define EEA_USER_FIRST 8'h00
`define EEA_USER_LAST 8'h2a
`define EEA_CFG_FIRST 8'h30
`define EEA_CFG_LAST 8'h37
`define EEA_CFG_LAST_IDX 3'h7
`define EEA_PWE_IDX 3'h0
`define EEA_SPW_FIRST_IDX 3'h1
`define EEA_SPW_LAST_IDX 3'h4
`define EEA_PWE_ON 8'hff

// ****************************************************************
// command codes and reset values
// ****************************************************************
`define EEA_CMD_NONE 8'h00
`define EEA_CMD_CFG_STORE 8'h11
`define EEA_CMD_CFG_LOAD 8'h12
`define EEA_CMD_BYTE_WR 8'h21
`define EEA_CMD_BYTE_RD 8'h22
`define EEA_RST_BYTE 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define EEA_CLK_MHZ 200
`define EEA_BOOT_TIME_MS 66

`endif

// file: eea_pkg.sv
`include "eea_regs.svh"

package eea_pkg;

   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_BOOT_WAIT,
      ST_IDLE,
      ST_CFG_STORE,
      ST_CFG_LOAD,
      ST_BYTE_WR,
      ST_BYTE_RD,
      ST_BYTE_CAP
   } eea_state_type;

   // true for a byte that single-byte commands may reach
   function automatic logic eea_nvm_addr_ok(input logic [7:0] a);
      eea_nvm_addr_ok = (a <= `EEA_USER_LAST) || (a >= `EEA_CFG_FIRST && a <= `EEA_CFG_LAST);
   endfunction : eea_nvm_addr_ok

   // true for an offset inside the configuration mirror
   function automatic logic eea_is_mirror(input logic [7:0] a);
      eea_is_mirror = (a >= `EEA_CFG_FIRST) && (a <= `EEA_CFG_LAST);
   endfunction : eea_is_mirror

endpackage : eea_pkg

// file: eea_nvm_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// nonvolatile byte array, registered read data
// ****************************************************************
module eea_nvm_mem #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 6
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o
);

   // cells start at their delivery value of zero and survive reset, like the real array
   logic [DATA_W-1:0] cell_reg [0:(1<<ADDR_W)-1] = '{default: '0};

   // cell writes, no reset branch
   always_ff @(posedge mclk_i) begin
      if (wr_en_i) begin
         cell_reg[addr_i] <= wdata_i;
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (rd_en_i) begin
         rdata_o <= cell_reg[addr_i];
      end
   end

endmodule : eea_nvm_mem

`default_nettype wire

// file: eea_nvm_access.sv
// Summary of operation
// RULE_01: write-only byte for password bits 15..8; reads give zero; resets to zero.
// RULE_02: write-only byte for password bits 23..16; reads give zero; resets to zero.
// RULE_03: write-only byte for password bits 31..24; reads give zero; resets to zero.
// RULE_04: address register picks the single byte; readable, write protected, resets zero.
// RULE_05: data register takes read bytes and supplies write bytes; write protected.
// RULE_06: command register is write-only, protected; a known code starts its operation.
// RULE_07: host disables auto refresh and waits for not busy before commanding.
// RULE_08: host writes the neutral code before every real command.
// RULE_09: command register resets to the neutral code that starts nothing.
// RULE_10: store command copies all eight mirror bytes into nonvolatile memory.
// RULE_11: load command copies all eight configuration bytes back into the mirror.
// RULE_12: byte write command programs the data byte at the held address.
// RULE_13: byte read command fetches the addressed byte into the data register.
// RULE_14: single-byte commands only reach user bytes and configuration bytes.
// RULE_15: after power-up and first refresh, clear all four password entry bytes.
// RULE_16: enable value of all ones requires entered password to match stored one.
// RULE_17: a fourth write-only byte holds password bits 7..0.
// RULE_18: busy stands from command acceptance until the transfer has finished.
// RULE_19: when locked, writes to address, data and command are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "eea_regs.svh"

module eea_nvm_access
   import eea_pkg::*;
#(
   parameter int BOOT_CYCLES = `EEA_BOOT_TIME_MS * `EEA_CLK_MHZ * 1000
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic auto_refresh_disable_i,
   output logic [7:0] reg_rdata_o,
   output logic nvm_transfer_busy_o
);

   // ****************************************************************
   // state
   // ****************************************************************
   eea_state_type state_reg, state_next;
   logic [31:0] boot_cnt_reg;
   logic boot_pending_reg;
   logic [2:0] idx_reg;
   logic phase_reg;
   logic armed_reg;
   logic [7:0] password_byte_zero_reg, password_byte_one_reg;
   logic [7:0] password_byte_two_reg, password_byte_three_reg;
   logic [7:0] nvm_target_address_reg, nvm_transfer_byte_reg, nvm_command_code_reg;
   logic [7:0] mirror_reg [0:7];
   logic wp_ok, cmd_go, addr_ok, load_done;
   logic mem_wr, mem_rd;
   logic [5:0] mem_addr;
   logic [7:0] cfg_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [2:0] wr_idx;

   localparam logic [31:0] BOOT_LAST = 32'(BOOT_CYCLES - 1);

   // ****************************************************************
   // protection and command decode
   // ****************************************************************
   // protection follows the mirrored enable and stored password bytes
   assign wp_ok = (mirror_reg[`EEA_PWE_IDX] != `EEA_PWE_ON) ||
      ({password_byte_three_reg, password_byte_two_reg, password_byte_one_reg, password_byte_zero_reg} ==
       {mirror_reg[4], mirror_reg[3], mirror_reg[2], mirror_reg[1]}); // RULE_16 RULE_17
   // a command only starts when idle, armed by the neutral code and auto refresh is off
   assign cmd_go = reg_wr_i && reg_addr_i == `EEA_OFS_NVM_CMD && wp_ok && state_reg == ST_IDLE &&
      armed_reg && auto_refresh_disable_i; // RULE_06 RULE_07 RULE_19
   assign addr_ok = eea_nvm_addr_ok(nvm_target_address_reg); // RULE_14
   assign load_done = state_reg == ST_CFG_LOAD && phase_reg && idx_reg == `EEA_CFG_LAST_IDX;
   assign wr_idx = reg_addr_i[2:0];

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_BOOT_WAIT: if (boot_cnt_reg == BOOT_LAST) state_next = ST_CFG_LOAD;
         ST_IDLE: begin
            if (cmd_go) begin
               if (reg_wdata_i == `EEA_CMD_CFG_STORE) state_next = ST_CFG_STORE; // RULE_10
               else if (reg_wdata_i == `EEA_CMD_CFG_LOAD) state_next = ST_CFG_LOAD; // RULE_11
               else if (reg_wdata_i == `EEA_CMD_BYTE_WR) state_next = ST_BYTE_WR; // RULE_12
               else if (reg_wdata_i == `EEA_CMD_BYTE_RD) state_next = ST_BYTE_RD; // RULE_13
            end
         end
         ST_CFG_STORE: if (idx_reg == `EEA_CFG_LAST_IDX) state_next = ST_IDLE;
         ST_CFG_LOAD: if (load_done) state_next = ST_IDLE;
         ST_BYTE_WR: state_next = ST_IDLE;
         ST_BYTE_RD: state_next = ST_BYTE_CAP;
         ST_BYTE_CAP: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_BOOT_WAIT;
      end else begin
         state_reg <= state_next;
      end
   end

   // busy runs one step ahead so it comes straight from a flop
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         nvm_transfer_busy_o <= 1'b1;
      end else begin
         nvm_transfer_busy_o <= state_next != ST_IDLE; // RULE_18
      end
   end

   // power-up wait before the first refresh; long, so it is a parameter
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         boot_cnt_reg <= '0;
      end else if (state_reg == ST_BOOT_WAIT) begin
         boot_cnt_reg <= boot_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         boot_pending_reg <= 1'b1;
      end else if (load_done) begin
         boot_pending_reg <= 1'b0;
      end
   end

   // byte index and read phase for the eight-byte sweeps
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         idx_reg <= '0;
         phase_reg <= 1'b0;
      end else if (state_reg == ST_CFG_STORE) begin
         idx_reg <= idx_reg + 3'h1;
      end else if (state_reg == ST_CFG_LOAD) begin
         phase_reg <= ~phase_reg;
         if (phase_reg) idx_reg <= idx_reg + 3'h1;
      end else begin
         idx_reg <= '0;
         phase_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // memory port
   // ****************************************************************
   // sweep offset within the configuration block; the array only needs its low six bits
   assign cfg_addr = `EEA_CFG_FIRST + {5'h0, idx_reg};

   // out-of-map addresses never touch the array
   always_comb begin
      mem_rd = (state_reg == ST_CFG_LOAD && !phase_reg) || (state_reg == ST_BYTE_RD && addr_ok); // RULE_11 RULE_13
      mem_wr = state_reg == ST_CFG_STORE || (state_reg == ST_BYTE_WR && addr_ok); // RULE_10 RULE_12
      mem_addr = (state_reg == ST_CFG_LOAD || state_reg == ST_CFG_STORE) ?
         cfg_addr[5:0] : nvm_target_address_reg[5:0];
      mem_wdata = (state_reg == ST_CFG_STORE) ? mirror_reg[idx_reg] : nvm_transfer_byte_reg;
   end

   eea_nvm_mem #(
      .DATA_W(8),
      .ADDR_W(6)
   ) u_mem (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(mem_wr),
      .rd_en_i(mem_rd),
      .addr_i(mem_addr),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   // ****************************************************************
   // host registers
   // ****************************************************************
   // entry bytes are never protected; the end of the first refresh wipes them
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         password_byte_zero_reg <= `EEA_RST_BYTE;
         password_byte_one_reg <= `EEA_RST_BYTE;
         password_byte_two_reg <= `EEA_RST_BYTE;
         password_byte_three_reg <= `EEA_RST_BYTE;
      end else if (load_done && boot_pending_reg) begin
         password_byte_zero_reg <= `EEA_RST_BYTE; // RULE_15
         password_byte_one_reg <= `EEA_RST_BYTE;
         password_byte_two_reg <= `EEA_RST_BYTE;
         password_byte_three_reg <= `EEA_RST_BYTE;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `EEA_OFS_PW_ZERO) password_byte_zero_reg <= reg_wdata_i; // RULE_17
         if (reg_addr_i == `EEA_OFS_PW_ONE) password_byte_one_reg <= reg_wdata_i; // RULE_01
         if (reg_addr_i == `EEA_OFS_PW_TWO) password_byte_two_reg <= reg_wdata_i; // RULE_02
         if (reg_addr_i == `EEA_OFS_PW_THREE) password_byte_three_reg <= reg_wdata_i; // RULE_03
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         nvm_target_address_reg <= `EEA_RST_BYTE;
      end else if (reg_wr_i && reg_addr_i == `EEA_OFS_NVM_ADDR && wp_ok) begin
         nvm_target_address_reg <= reg_wdata_i; // RULE_04 RULE_19
      end
   end

   // a finishing byte read wins over a host write in the same cycle
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         nvm_transfer_byte_reg <= `EEA_RST_BYTE;
      end else if (state_reg == ST_BYTE_CAP && addr_ok) begin
         nvm_transfer_byte_reg <= mem_rdata; // RULE_13
      end else if (reg_wr_i && reg_addr_i == `EEA_OFS_NVM_DATA && wp_ok) begin
         nvm_transfer_byte_reg <= reg_wdata_i; // RULE_05 RULE_19
      end
   end

   // only the neutral code arms the next command
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         nvm_command_code_reg <= `EEA_CMD_NONE; // RULE_09
         armed_reg <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == `EEA_OFS_NVM_CMD && wp_ok && state_reg == ST_IDLE) begin
         nvm_command_code_reg <= reg_wdata_i; // RULE_06
         armed_reg <= reg_wdata_i == `EEA_CMD_NONE; // RULE_08
      end
   end

   // mirror: the refresh sweep has priority over host writes
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < 8; i++) mirror_reg[i] <= `EEA_RST_BYTE;
      end else if (state_reg == ST_CFG_LOAD && phase_reg) begin
         mirror_reg[idx_reg] <= mem_rdata; // RULE_11
      end else if (reg_wr_i && eea_is_mirror(reg_addr_i) && wp_ok) begin
         mirror_reg[wr_idx] <= reg_wdata_i;
      end
   end

   // read mux; write-only bytes and stored password bytes read zero
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= `EEA_RST_BYTE;
      end else if (reg_rd_i) begin
         if (reg_addr_i == `EEA_OFS_NVM_ADDR) reg_rdata_o <= nvm_target_address_reg; // RULE_04
         else if (reg_addr_i == `EEA_OFS_NVM_DATA) reg_rdata_o <= nvm_transfer_byte_reg; // RULE_05
         else if (eea_is_mirror(reg_addr_i) && (wr_idx < `EEA_SPW_FIRST_IDX || wr_idx > `EEA_SPW_LAST_IDX))
            reg_rdata_o <= mirror_reg[wr_idx];
         else reg_rdata_o <= `EEA_RST_BYTE; // RULE_01 RULE_02 RULE_03
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_store_start;
      state_reg == ST_IDLE ##1 state_reg == ST_CFG_STORE;
   endsequence
   sequence s_load_start;
      state_reg != ST_CFG_LOAD ##1 state_reg == ST_CFG_LOAD;
   endsequence

   a_pw_read_zero: assert property ( // RULE_01 RULE_02 RULE_03
      reg_rd_i && reg_addr_i >= `EEA_OFS_PW_ZERO && reg_addr_i <= `EEA_OFS_PW_THREE |=> reg_rdata_o == 8'h00)
      else $error("password byte read returned nonzero");
   a_addr_write_taken: assert property ( // RULE_04
      reg_wr_i && reg_addr_i == `EEA_OFS_NVM_ADDR && wp_ok |=> nvm_target_address_reg == $past(reg_wdata_i))
      else $error("address write lost");
   a_locked_write_dropped: assert property ( // RULE_19
      reg_wr_i && reg_addr_i == `EEA_OFS_NVM_ADDR && !wp_ok |=> $stable(nvm_target_address_reg))
      else $error("locked address write was taken");
   a_cmd_reset_neutral: assert property ( // RULE_09
      $past(state_reg) == ST_BOOT_WAIT && state_reg == ST_BOOT_WAIT |-> nvm_command_code_reg == `EEA_CMD_NONE)
      else $error("command code not neutral after reset");
   a_cfg_store_len: assert property ( // RULE_10
      s_store_start |-> (state_reg == ST_CFG_STORE && mem_wr)[*8] ##1 state_reg == ST_IDLE)
      else $error("store sweep not eight cycles");
   a_cfg_load_len: assert property ( // RULE_11
      s_load_start |-> ##15 state_reg == ST_CFG_LOAD ##1 state_reg == ST_IDLE)
      else $error("load sweep not sixteen cycles");
   a_byte_rd_capture: assert property ( // RULE_13
      state_reg == ST_BYTE_RD && addr_ok |=> ##1 nvm_transfer_byte_reg == $past(mem_rdata))
      else $error("byte read not captured");
   a_byte_wr_cell: assert property ( // RULE_12 RULE_14
      state_reg == ST_IDLE && cmd_go && reg_wdata_i == `EEA_CMD_BYTE_WR |=> mem_wr == addr_ok)
      else $error("byte write strobe wrong");
   a_busy_follows: assert property ( // RULE_18
      cmd_go && reg_wdata_i == `EEA_CMD_BYTE_RD |=> nvm_transfer_busy_o [*2] ##1 !nvm_transfer_busy_o)
      else $error("busy does not span byte read");
   a_boot_clear: assert property ( // RULE_15
      load_done && boot_pending_reg |=> password_byte_zero_reg == 8'h00 && password_byte_three_reg == 8'h00)
      else $error("password entry not cleared after first refresh");
   a_unarmed_ignored: assert property ( // RULE_06
      reg_wr_i && reg_addr_i == `EEA_OFS_NVM_CMD && !armed_reg |=> state_reg != ST_CFG_STORE)
      else $error("command ran without arming");

endmodule : eea_nvm_access

`default_nettype wire

// file: eea_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host controller behind the register port
// ****************************************************************
module eea_host_model (
   input wire logic mclk_i,
   input wire logic busy_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic refresh_dis_o
);
   // bus idle at time zero; refresh left running until a command needs it off
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      refresh_dis_o = 1'b0;
   end

   // one-cycle write strobe; data is scrambled after release so nothing leans on a stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask : wr

   // one-cycle read strobe; the answer is collected by whoever watches the bus
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
   endtask : rd

   // command entry: refresh disable set from dis, wait for idle, neutral code, then the real code
   task automatic cmd(input logic [7:0] code, input logic dis, output logic ok);
      int n;
      n = 0;
      @(posedge mclk_i);
      refresh_dis_o <= dis;
      while (busy_i !== 1'b0 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      ok = (n < 100);
      wr(8'h27, 8'h00);
      wr(8'h27, code);
   endtask : cmd
endmodule : eea_host_model

`default_nettype wire

// file: eea_nvm_access_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "eea_regs.svh"

module eea_nvm_access_test;
   logic mclk_i;
   logic rst_b_i;
   logic reg_wr;
   logic reg_rd;
   logic refresh_dis;
   logic busy;
   logic rd_seen;
   logic ok;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] rdata;
   logic [7:0] m_val;
   logic [7:0] d_val;
   logic [7:0] a_val;
   logic [31:0] pw;
   logic [7:0] exp_q[$];
   int err_count;
   int n_tests;

   // ****************************************************************
   // clock, design and host
   // ****************************************************************
   initial mclk_i = 1'b0;
   always #2.5 mclk_i = ~mclk_i;

   // short boot wait keeps the run small
   eea_nvm_access #(.BOOT_CYCLES(8)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .auto_refresh_disable_i(refresh_dis), .reg_rdata_o(rdata), .nvm_transfer_busy_o(busy));

   eea_host_model host (.mclk_i(mclk_i), .busy_i(busy), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .refresh_dis_o(refresh_dis));

   // ****************************************************************
   // checking helpers
   // ****************************************************************
   task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   // note the expectation first, so the watcher always finds it
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd_exp

   // read data stands one cycle after the strobe, so compare at the following edge
   always @(posedge mclk_i) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("read without note", 8'h00, 8'hff);
         end else begin
            check("read data", exp_q.pop_front(), rdata);
         end
      end
      rd_seen <= reg_rd;
   end

   // bounded wait for idle; a hang ends the run as a mismatch
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 200) begin
         check("idle wait", 8'h00, 8'h01);
         tally_and_finish();
      end
   endtask : wait_idle

   // issue a command and count how many sampled cycles busy stands
   task automatic do_cmd(input logic [7:0] code, input logic dis, input logic [7:0] exp_n);
      int n;
      host.cmd(code, dis, ok);
      if (ok !== 1'b1) begin
         check("command wait", 8'h00, 8'h01);
         tally_and_finish();
      end
      n = 0;
      #1;
      while (busy === 1'b1 && n < 64) begin
         n++;
         @(posedge mclk_i);
         #1;
      end
      check("busy cycles", exp_n, n[7:0]);
   endtask : do_cmd

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rst_b_i = 1'b0;
      rd_seen = 1'b0;
      err_count = 0;
      n_tests = 0;
      void'($urandom(32'h0da1));
      repeat (12) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      wait_idle();
      // reset values; entry bytes and command read as zero
      for (int i = 8'h21; i <= 8'h27; i++) begin
         rd_exp(i[7:0], `EEA_RST_BYTE);
      end
      // give the mirror defined contents, then store it
      m_val = 8'($urandom);
      d_val = 8'($urandom);
      for (int i = 8'h30; i <= 8'h37; i++) begin
         host.wr(i[7:0], (i == 8'h36) ? m_val : 8'h00);
      end
      do_cmd(`EEA_CMD_CFG_STORE, 1'b1, 8'd8);
      // user byte write then read back through the data register
      a_val = 8'($urandom_range(8'h2a, 8'h00));
      host.wr(`EEA_OFS_NVM_ADDR, a_val);
      host.wr(`EEA_OFS_NVM_DATA, d_val);
      do_cmd(`EEA_CMD_BYTE_WR, 1'b1, 8'd1);
      host.wr(`EEA_OFS_NVM_DATA, ~d_val);
      do_cmd(`EEA_CMD_BYTE_RD, 1'b1, 8'd2);
      rd_exp(`EEA_OFS_NVM_DATA, d_val);
      rd_exp(`EEA_OFS_NVM_ADDR, a_val);
      // config byte written singly, mirror spoiled, then reloaded
      host.wr(`EEA_OFS_NVM_ADDR, 8'h37);
      do_cmd(`EEA_CMD_BYTE_WR, 1'b1, 8'd1);
      host.wr(8'h36, ~m_val);
      do_cmd(`EEA_CMD_CFG_LOAD, 1'b1, 8'd16);
      rd_exp(8'h36, m_val);
      rd_exp(8'h37, d_val);
      // code without the neutral arming write starts nothing
      host.wr(`EEA_OFS_NVM_CMD, `EEA_CMD_BYTE_RD);
      #1;
      check("busy unarmed", 8'h00, {7'h00, busy});
      // refresh still running refuses the command
      do_cmd(`EEA_CMD_BYTE_RD, 1'b0, 8'd0);
      // address outside both ranges leaves the data register alone
      host.wr(`EEA_OFS_NVM_DATA, 8'h3c);
      host.wr(`EEA_OFS_NVM_ADDR, 8'h2c);
      do_cmd(`EEA_CMD_BYTE_RD, 1'b1, 8'd2);
      rd_exp(`EEA_OFS_NVM_DATA, 8'h3c);
      // enable protection with a stored word the entry bytes do not hold
      pw = $urandom | 32'h1;
      for (int i = 0; i < 4; i++) begin
         host.wr(8'h31 + i[7:0], pw[8*i +: 8]);
      end
      host.wr(8'h30, `EEA_PWE_ON);
      host.wr(`EEA_OFS_NVM_ADDR, 8'h5a);
      rd_exp(`EEA_OFS_NVM_ADDR, 8'h2c);
      do_cmd(`EEA_CMD_CFG_LOAD, 1'b1, 8'd0);
      // matching entry unlocks; entry bytes still read as zero
      for (int i = 0; i < 4; i++) begin
         host.wr(8'h21 + i[7:0], pw[8*i +: 8]);
         rd_exp(8'h21 + i[7:0], 8'h00);
      end
      host.wr(`EEA_OFS_NVM_ADDR, 8'h5a);
      rd_exp(`EEA_OFS_NVM_ADDR, 8'h5a);
      do_cmd(`EEA_CMD_CFG_STORE, 1'b1, 8'd8);
      // second reset: stored lock reloads and the cleared entry no longer matches
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      // matching entry made during the boot wait must be wiped by the first refresh
      for (int i = 0; i < 4; i++) begin
         host.wr(8'h21 + i[7:0], pw[8*i +: 8]);
      end
      wait_idle();
      host.wr(`EEA_OFS_NVM_ADDR, 8'h5a);
      rd_exp(`EEA_OFS_NVM_ADDR, 8'h00);
      repeat (3) @(posedge mclk_i);
      check("unread notes", 8'h00, 8'(exp_q.size()));
      tally_and_finish();
   end
endmodule : eea_nvm_access_test

`default_nettype wire
